// file: rtl/tsf_regs.svh
// register offsets, field positions and reset values for the trap block
`ifndef TSF_REGS_SVH
`define TSF_REGS_SVH

// privileged register select codes (block-local choice)
`define TSF_SEL_TRAP_SUMMARY 1'h0
`define TSF_SEL_FW_BASE      1'h1

// trap summary field positions
`define TSF_SUM_REQ_HI   47
`define TSF_SUM_REQ_LO   42
`define TSF_SUM_PC_SIGN  41
`define TSF_SUM_RSV_HI   40
`define TSF_SUM_RSV_LO   14
`define TSF_SUM_VADDR    13
`define TSF_SUM_REG_HI   12
`define TSF_SUM_REG_LO   8
`define TSF_SUM_INT      7
`define TSF_SUM_FLAG_HI  6
`define TSF_SUM_FLAG_LO  1
`define TSF_SUM_SWC      0

// firmware base field and reset value
`define TSF_FWB_HI       43
`define TSF_FWB_LO       15
`define TSF_FWB_RESET    29'h0000000

`endif

// file: rtl/tsf_pkg.sv
// types shared by the trap summary and firmware base block
`default_nettype none
package tsf_pkg;
	// source of the trap being delivered
	typedef enum logic [1:0]
	{
		TSF_SRC_ARITH,
		TSF_SRC_LOAD,
		TSF_SRC_STORE,
		TSF_SRC_OTHER
	} tsf_src_t;

	// one trap delivery from the execution units
	typedef struct packed
	{
		logic        deliver;      // one-cycle delivery strobe
		tsf_src_t    src;          // trap source class
		logic [4:0]  dest_reg;     // destination register number
		logic [4:0]  src_reg;      // store source register number
		logic        int_ovf;      // integer unit overflow
		logic [5:0]  arith_flags;  // conv,inexact,unf,ovf,dze,inv
		logic [5:0]  set_reqs;     // same order, control set requests
		logic        fetch_acv;    // fetch access violation
		logic        acv_in_vaddr; // address latched in fault vaddr
		logic        pc_sign_err;  // bad sign extension, 48-bit mode
		logic        soft_compl;   // software completion qualifier
	} tsf_trap_t;
endpackage
`default_nettype wire

// file: rtl/tsf_trap_unit.sv
// trap summary capture and firmware base register
//
// Function
// - summary loads on trap delivery, read-only
// - arithmetic trap records destination register
// - store gives source, load gives destination
// - operand register field at bits 12:8
// - bit 13 marks fetch fault in vaddr
// - bits 47:42 request control flag sets
// - bits 63:48 copy bit 47
// - bit 41 flags bad exception pc sign
// - bit 7 set for integer overflow
// - bits 6:1 flag arithmetic conditions
// - bit 0 flags software completion qualifier
// - base writable, cleared by chip reset only
// - base holds bits 43:15, rest zero
`include "tsf_regs.svh"
`default_nettype none
module tsf_trap_unit
(
	input  wire logic              mclk_in,       // core clock
	input  wire logic              rst_n_in,      // chip reset, sync
	input  wire tsf_pkg::tsf_trap_t trap_in,      // trap delivery
	input  wire logic              rd_en_in,      // privileged read
	input  wire logic              wr_en_in,      // privileged write
	input  wire logic              sel_in,        // register select
	input  wire logic [63:0]       wr_data_in,    // write data
	output logic      [63:0]       rd_data_out,   // read data, registered
	output logic                   rd_valid_out   // read data valid
);
	import tsf_pkg::*;

	// captured summary fields, the rest is derived on read
	logic [5:0]  req;          // control flag set requests
	logic        pc_sign;      // exception pc sign error
	logic        vaddr_flag;   // fetch fault address in vaddr
	logic [4:0]  opnd;         // operand register number
	logic        int_flag;     // integer overflow source
	logic [5:0]  flags;        // arithmetic condition flags
	logic        soft_completion_ok;          // software completion possible
	logic [28:0] fw_base;      // firmware base address bits
	logic [63:0] next_rd_data; // read data next value
	logic        next_rd_valid;
	logic [5:0]  next_req;
	logic        next_pc_sign;
	logic        next_vaddr_flag;
	logic [4:0]  next_opnd;
	logic        next_int_flag;
	logic [5:0]  next_flags;
	logic        next_swc;
	logic [28:0] next_fw_base;

	// assemble the full summary word from captured fields
	function automatic logic [63:0] pack_summary(
		input logic [5:0] r, input logic p, input logic v,
		input logic [4:0] o, input logic i, input logic [5:0] f,
		input logic s);
		logic [63:0] w;
		w = 64'h0000000000000000;
		w[63:48] = {16{r[5]}};
		w[`TSF_SUM_REQ_HI:`TSF_SUM_REQ_LO] = r;
		w[`TSF_SUM_PC_SIGN] = p;
		w[`TSF_SUM_VADDR] = v;
		w[`TSF_SUM_REG_HI:`TSF_SUM_REG_LO] = o;
		w[`TSF_SUM_INT] = i;
		w[`TSF_SUM_FLAG_HI:`TSF_SUM_FLAG_LO] = f;
		w[`TSF_SUM_SWC] = s;
		return w;
	endfunction

	// summary capture: only a delivery changes it, no write path
	always_comb
	begin
		next_req        = req;
		next_pc_sign    = pc_sign;
		next_vaddr_flag = vaddr_flag;
		next_opnd       = opnd;
		next_int_flag   = int_flag;
		next_flags      = flags;
		next_swc        = soft_completion_ok;
		if (trap_in.deliver)
		begin
			next_req        = trap_in.set_reqs;
			next_pc_sign    = trap_in.fetch_acv & trap_in.pc_sign_err;
			next_vaddr_flag = trap_in.fetch_acv & trap_in.acv_in_vaddr;
			next_int_flag   = trap_in.int_ovf;
			next_flags      = trap_in.arith_flags;
			next_swc        = trap_in.soft_compl;
			// operand field choice by trap source
			case (trap_in.src)
				TSF_SRC_ARITH: next_opnd = trap_in.dest_reg;
				TSF_SRC_LOAD:  next_opnd = trap_in.dest_reg;
				TSF_SRC_STORE: next_opnd = trap_in.src_reg;
				default:       next_opnd = 5'h00;
			endcase
		end
	end

	// summary registers
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			req        <= 6'h00;
			pc_sign    <= 1'b0;
			vaddr_flag <= 1'b0;
			opnd       <= 5'h00;
			int_flag   <= 1'b0;
			flags      <= 6'h00;
			soft_completion_ok        <= 1'b0;
		end
		else
		begin
			req        <= next_req;
			pc_sign    <= next_pc_sign;
			vaddr_flag <= next_vaddr_flag;
			opnd       <= next_opnd;
			int_flag   <= next_int_flag;
			flags      <= next_flags;
			soft_completion_ok        <= next_swc;
		end
	end

	// firmware base: only the address bits store, others dropped
	always_comb
	begin
		next_fw_base = fw_base;
		if (wr_en_in && sel_in == `TSF_SEL_FW_BASE)
		begin
			next_fw_base = wr_data_in[`TSF_FWB_HI:`TSF_FWB_LO];
		end
	end

	// chip reset is the only clear; no other reset reaches it
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			fw_base <= `TSF_FWB_RESET;
		else
			fw_base <= next_fw_base;
	end

	// read port: registered data one cycle after the request
	always_comb
	begin
		next_rd_valid = rd_en_in;
		next_rd_data  = 64'h0000000000000000;
		if (rd_en_in)
		begin
			if (sel_in == `TSF_SEL_FW_BASE)
				next_rd_data = {20'h00000, fw_base, 15'h0000};
			else
				next_rd_data = pack_summary(req, pc_sign, vaddr_flag,
					opnd, int_flag, flags, soft_completion_ok);
		end
	end

	// read data registers
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			rd_data_out  <= 64'h0000000000000000;
			rd_valid_out <= 1'b0;
		end
		else
		begin
			rd_data_out  <= next_rd_data;
			rd_valid_out <= next_rd_valid;
		end
	end

	// assertions
	a_sum_sign_ext: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		rd_valid_out && !$past(sel_in) |->
		rd_data_out[63:48] == {16{rd_data_out[47]}})
		else $error("summary top bits not sign extended");
	a_sum_reserved: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		rd_valid_out && !$past(sel_in) |->
		rd_data_out[40:14] == 27'h0000000)
		else $error("summary reserved bits not zero");
	a_base_zero_bits: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		rd_valid_out && $past(sel_in) |->
		rd_data_out[63:44] == 20'h00000 &&
		rd_data_out[14:0] == 15'h0000)
		else $error("base reserved bits not zero");
	a_base_write: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		wr_en_in && sel_in ##1 rd_en_in && sel_in && !wr_en_in |=>
		rd_data_out[43:15] == $past(wr_data_in[43:15], 2))
		else $error("base write not read back");
	a_sum_hold: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		!trap_in.deliver |=> $stable(opnd) && $stable(req)
		&& $stable(flags))
		else $error("summary changed without delivery");
	a_store_opnd: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		trap_in.deliver && trap_in.src == TSF_SRC_STORE
		|=> opnd == $past(trap_in.src_reg))
		else $error("store source register not captured");
	a_arith_opnd: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		trap_in.deliver && trap_in.src != TSF_SRC_STORE
		&& trap_in.src != TSF_SRC_OTHER
		|=> opnd == $past(trap_in.dest_reg))
		else $error("destination register not captured");
	a_vaddr_flag: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		trap_in.deliver |=> vaddr_flag ==
		$past(trap_in.fetch_acv && trap_in.acv_in_vaddr))
		else $error("fetch fault address flag wrong");
	a_read_field: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		rd_en_in && !sel_in |=> rd_data_out[12:8] ==
		$past(opnd) && rd_data_out[7] == $past(int_flag)
		&& rd_data_out[0] == $past(soft_completion_ok))
		else $error("summary read data mismatch");

	// covers
	c_trap_read: cover property (@(posedge mclk_in) disable iff
		(!rst_n_in) trap_in.deliver ##1 rd_en_in && !sel_in);
	c_store_trap: cover property (@(posedge mclk_in) disable iff
		(!rst_n_in) trap_in.deliver && trap_in.src == TSF_SRC_STORE);
	c_base_rw: cover property (@(posedge mclk_in) disable iff
		(!rst_n_in) wr_en_in && sel_in ##1 rd_en_in && sel_in);
endmodule
`default_nettype wire

// file: bench/tsf_trap_model.sv
// execution-unit trap source model
`default_nettype none
module tsf_trap_model
(
	input  wire logic            mclk_in,  // core clock
	output var tsf_pkg::tsf_trap_t trap_out  // trap delivery to block
);
	timeunit 1ns;
	timeprecision 1ps;
	import tsf_pkg::*;

	// quiet bus at start
	initial trap_out = '0;

	// one-cycle delivery, fields valid only with the strobe
	task automatic send(input tsf_trap_t t);
		tsf_trap_t w; // word built before it reaches the pins
		w = t;
		w.deliver = 1'b1;
		@(negedge mclk_in);
		trap_out = w;
		// stale fields flipped so nothing leans on old values
		w = ~t;
		w.deliver = 1'b0;
		@(negedge mclk_in);
		trap_out = w;
	endtask
endmodule
`default_nettype wire

// file: bench/test_trap_summary_and_firmware_base.sv
// self-checking bench for trap summary and firmware base
`default_nettype none
module test_trap_summary_and_firmware_base;
	timeunit 1ns;
	timeprecision 1ps;
	import tsf_pkg::*;

	logic        mclk_in;     // core clock
	logic        rst_n_in;    // chip reset
	logic        rd_en_in;    // read strobe
	logic        wr_en_in;    // write strobe
	logic        sel_in;      // register select
	logic [63:0] wr_data_in;  // write data
	logic [63:0] rd_data_out; // read data
	logic        rd_valid_out; // read valid
	tsf_trap_t   trap_in;     // trap delivery
	int          num_errors;  // mismatches
	int          n_checks;    // comparisons

	tsf_trap_unit i_dut
	(
		.mclk_in      (mclk_in),
		.rst_n_in     (rst_n_in),
		.trap_in      (trap_in),
		.rd_en_in     (rd_en_in),
		.wr_en_in     (wr_en_in),
		.sel_in       (sel_in),
		.wr_data_in   (wr_data_in),
		.rd_data_out  (rd_data_out),
		.rd_valid_out (rd_valid_out)
	);

	tsf_trap_model i_model
	(
		.mclk_in  (mclk_in),
		.trap_out (trap_in)
	);

	// 250 MHz clock
	initial
	begin
		mclk_in = 1'b0;
		forever #2 mclk_in = ~mclk_in;
	end

	// expected summary word worked out from the trap fields
	function automatic logic [63:0] exp_sum(input tsf_trap_t t);
		logic [4:0] r;
		r = (t.src == TSF_SRC_STORE) ? t.src_reg :
			(t.src == TSF_SRC_OTHER) ? 5'h00 : t.dest_reg;
		return {{16{t.set_reqs[5]}}, t.set_reqs,
			t.fetch_acv & t.pc_sign_err, 27'h0000000,
			t.fetch_acv & t.acv_in_vaddr, r, t.int_ovf,
			t.arith_flags, t.soft_compl};
	endfunction

	// compare and report
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// privileged read, answer one cycle later
	task automatic rd(input logic s, input logic [63:0] exp);
		@(negedge mclk_in);
		rd_en_in = 1'b1;
		sel_in = s;
		@(negedge mclk_in);
		rd_en_in = 1'b0;
		chk({63'h0, rd_valid_out}, 64'h1);
		chk(rd_data_out, exp);
	endtask

	// privileged write
	task automatic wr(input logic s, input logic [63:0] d);
		@(negedge mclk_in);
		wr_en_in = 1'b1;
		sel_in = s;
		wr_data_in = d;
		@(negedge mclk_in);
		wr_en_in = 1'b0;
	endtask

	// base keeps only its address field, summary refuses writes
	task automatic t_base();
		rd(1'b1, 64'h0);
		wr(1'b1, 64'hFFFFFFFFFFFFFFFF);
		rd(1'b1, 64'h00000FFFFFFF8000);
		wr(1'b0, 64'hFFFFFFFFFFFFFFFF);
		rd(1'b0, 64'h0);
	endtask

	// arithmetic, store, load and other-source traps, each read twice
	task automatic t_traps();
		tsf_trap_t v [4];
		v[0] = '{1'b0, TSF_SRC_ARITH, 5'h1F, 5'h03, 1'b1, 6'h2A,
			6'h20, 1'b0, 1'b1, 1'b1, 1'b1};
		v[1] = '{1'b0, TSF_SRC_STORE, 5'h04, 5'h1B, 1'b0, 6'h15,
			6'h1F, 1'b1, 1'b0, 1'b1, 1'b0};
		v[2] = '{1'b0, TSF_SRC_LOAD, 5'h11, 5'h0E, 1'b0, 6'h01,
			6'h00, 1'b1, 1'b1, 1'b0, 1'b0};
		// other source: operand field is captured as zero
		v[3] = '{1'b0, TSF_SRC_OTHER, 5'h0A, 5'h15, 1'b0, 6'h3F,
			6'h3F, 1'b1, 1'b1, 1'b1, 1'b1};
		for (int i = 0; i < 4; i++)
		begin
			i_model.send(v[i]);
			rd(1'b0, exp_sum(v[i]));
			rd(1'b0, exp_sum(v[i]));
		end
	endtask

	// chip reset clears the base again
	task automatic t_rereset();
		wr(1'b1, 64'hFFFFFFFFFFFFFFFF);
		@(negedge mclk_in);
		rst_n_in = 1'b0;
		repeat (5) @(negedge mclk_in);
		rst_n_in = 1'b1;
		rd(1'b1, 64'h0);
		rd(1'b0, 64'h0);
	endtask

	// write then read next cycle, read beside write, idle outputs
	task automatic t_b2b();
		@(negedge mclk_in);
		wr_en_in = 1'b1;
		sel_in = 1'b1;
		wr_data_in = 64'hFFF0012345678FFF;
		@(negedge mclk_in);
		wr_en_in = 1'b0;
		rd_en_in = 1'b1;
		@(negedge mclk_in);
		chk(rd_data_out, 64'h0000012345678000);
		// same-cycle read sees the value from before the write
		wr_en_in = 1'b1;
		wr_data_in = 64'h0;
		@(negedge mclk_in);
		wr_en_in = 1'b0;
		rd_en_in = 1'b0;
		chk(rd_data_out, 64'h0000012345678000);
		rd(1'b1, 64'h0);
		// no read in the prior cycle: valid low, data zero
		@(negedge mclk_in);
		chk({63'h0, rd_valid_out}, 64'h0);
		chk(rd_data_out, 64'h0);
	endtask

	// verdict
	task automatic close_out();
		if (num_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// hang guard
	initial
	begin
		#20000;
		num_errors++;
		close_out();
	end

	// main sequence
	initial
	begin
		num_errors = 0;
		n_checks = 0;
		rst_n_in = 1'b0;
		rd_en_in = 1'b0;
		wr_en_in = 1'b0;
		sel_in = 1'b0;
		wr_data_in = 64'h0;
		repeat (5) @(negedge mclk_in);
		rst_n_in = 1'b1;
		t_base();
		t_b2b();
		t_traps();
		t_rereset();
		close_out();
	end
endmodule
`default_nettype wire
